// ---- logic/draw_ctl_pkg.sv ----
package draw_ctl_pkg;
  // register byte addresses (printed offsets are indexes, not all /4)
  localparam int unsigned AUX_STATUS_IDX = 9;
  localparam int unsigned ENGINE_CTRL_IDX = 17;
  localparam logic [7:0] AUX_STATUS_ADDR = 8'h24;
  localparam logic [7:0] ENGINE_CTRL_ADDR = 8'h44;
  localparam logic [7:0] LAUNCH_ADDR = 8'h7C;
  localparam logic [7:0] DIR_ADDR = 8'h80;
  localparam logic [7:0] DEST_XY_ADDR = 8'h84;
  localparam logic [7:0] LENGTH_ADDR = 8'h88;
  localparam logic [7:0] DIM_ADDR = 8'h8C;
  localparam logic [7:0] LINE_ADDR = 8'h90;
  localparam logic [7:0] STEP_ADDR = 8'h94;
  localparam logic [7:0] PAT_X_ADDR = 8'h98;
  // field positions
  localparam int unsigned CTRL_BUSY_BIT = 7;
  localparam int unsigned CTRL_IRQ_EN_BIT = 0;
  localparam int unsigned AUX_BUSY_BIT = 7;
  localparam int unsigned OPTYPE_LSB = 24;
  localparam int unsigned COORD_W = 14;
  localparam int unsigned DIM_W = 12;
  // limits of the coordinate window
  localparam logic signed [13:0] COORD_MIN = -14'sd2048;
  localparam logic signed [13:0] COORD_MAX = 14'sd6143;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [3:0] {
    OP_STEP_RD = 4'b0010,
    OP_LINE_RD = 4'b0011,
    OP_STEP_WR = 4'b0100,
    OP_LINE_WR = 4'b0101,
    OP_BLOCK = 4'b1000,
    OP_BLOCK_INV = 4'b1001,
    OP_BLOCK_FILL = 4'b1010
  } op_type_t;

  // direction code carried as one packed group
  typedef struct packed {
    logic x_negative_flag;
    logic y_negative_flag;
    logic y_major_flag;
  } dir_code_t;

  typedef struct packed {
    logic signed [13:0] x;
    logic signed [13:0] y;
  } point_t;
endpackage

// ---- logic/pel_walker.sv ----
`timescale 1ns/1ps
// walks one pel per cycle over a rectangle or a line and reports
// each pel to be written; the last pel raises last_o with valid_o
module pel_walker #(
  parameter int unsigned DIM_W = 12
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic start_i,
  input wire logic hold_i,
  input wire logic [DIM_W-1:0] width_i,
  input wire logic [DIM_W-1:0] height_i,
  // pel stream
  output logic valid_o,
  output logic last_o,
  output logic [DIM_W-1:0] col_o,
  output logic [DIM_W-1:0] row_o
);
  logic run_q;
  logic [DIM_W-1:0] col_q;
  logic [DIM_W-1:0] row_q;
  logic end_col;
  logic end_row;

  initial begin
    if (DIM_W < 2 || DIM_W > 16) $error("pel_walker: DIM_W out of range");
  end

  assign end_col = (col_q == width_i);
  assign end_row = (row_q == height_i);

  // a held walker emits nothing so a paused read never loses a pel
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
      col_q <= '0;
      row_q <= '0;
    end else if (start_i) begin
      run_q <= 1'b1;
      col_q <= '0;
      row_q <= '0;
    end else if (run_q && !hold_i) begin
      if (end_col) begin
        col_q <= '0;
        if (end_row) begin
          run_q <= 1'b0;
        end else begin
          row_q <= row_q + 1'b1;
        end
      end else begin
        col_q <= col_q + 1'b1;
      end
    end
  end

  assign valid_o = run_q && !hold_i;
  assign last_o = run_q && !hold_i && end_col && end_row;
  assign col_o = col_q;
  assign row_o = row_q;
endmodule // pel_walker

// ---- logic/drawing_engine_op_control.sv ----
`timescale 1ns/1ps
// Operation
// - started operation runs alone; busy stays set until fully complete
// - host read of control register pauses the operation during the read
// - auxiliary busy bit readable without stalling the operation
// - optional level completion interrupt, shareable with other sources
// - launch write starts the operation and does not wait
// - block transfer order follows direction code; host picks it
// - inverting transfer flips vertically, walking rows from the far end back to the near end
// - area fill uses a 1bpp work plane sized like the destination (no plane here: outlines are column 0 and the LENGTH_ADDR column)
// - fill scans left to right toggling at each outline pel
// - fill keeps top and left edges, drops bottom and right
// - target coordinates span -2048..6143; outside bitmap is clipped
// - bitmap dimensions limited to 0..4095
// - length register takes 0..4095 only
// - line end leaves error term, steps, target and pattern x updated
// - coordinates are 14 bits and wrap instead of saturating
// - position registers undefined after reset; host initialises them (reset here clears them to zero)
// - operation type field selects step, line and transfer kinds
// - direction bits: negative x, negative y, y major
module drawing_engine_op_control #(
  parameter int unsigned DIM_W = draw_ctl_pkg::DIM_W
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address, data and response
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // pel write stream and completion
  output logic pel_we_o,
  output logic pel_fill_o,
  output logic [27:0] pel_addr_o,
  output logic done_irq_o
);
  initial begin
    if (DIM_W != 12) $error("drawing_engine_op_control: DIM_W must be 12");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_PAUSE = 2'b10
  } eng_state_t;

  eng_state_t state_q;
  logic [7:0] ctrl_q;
  logic [3:0] op_q;
  draw_ctl_pkg::dir_code_t dir_q;
  draw_ctl_pkg::point_t dest_q;
  draw_ctl_pkg::point_t cur_q;
  logic [DIM_W-1:0] len_q;
  logic [DIM_W-1:0] wid_q;
  logic [DIM_W-1:0] hgt_q;
  logic [DIM_W-1:0] clip_w_q;
  logic [DIM_W-1:0] clip_h_q;
  logic signed [15:0] err_q;
  logic signed [15:0] k1_q;
  logic signed [15:0] k2_q;
  logic [13:0] pat_x_q;
  logic fill_on_q;
  logic irq_q;
  logic [7:0] aw_q;
  logic aw_have_q;
  logic [31:0] w_q;
  logic w_have_q;
  logic [7:0] ar_q;
  logic ar_have_q;
  logic ctrl_rd_q;
  logic pel_we_q;
  logic pel_fill_q;
  logic [27:0] pel_addr_q;
  logic [1:0] bresp_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;

  logic wr_fire;
  logic launch;
  logic hold;
  logic w_valid;
  logic w_last;
  logic [DIM_W-1:0] w_col;
  logic [DIM_W-1:0] w_row;
  logic is_line;
  logic [DIM_W-1:0] walk_w;
  logic [DIM_W-1:0] walk_h;
  logic signed [13:0] px;
  logic signed [13:0] py;
  logic in_bitmap;
  logic outline_pel;

  // write commits once address and data have both arrived
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign launch = wr_fire && aw_q == draw_ctl_pkg::LAUNCH_ADDR;
  // only a control-register read holds the walker, status reads do not
  assign hold = ctrl_rd_q;
  assign is_line = op_q[3] == 1'b0;
  assign walk_w = is_line ? len_q : wid_q;
  assign walk_h = is_line ? '0 : hgt_q;

  pel_walker #(
    .DIM_W(DIM_W)
  ) walker_u (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(launch),
    .hold_i(hold),
    .width_i(walk_w),
    .height_i(walk_h),
    .valid_o(w_valid),
    .last_o(w_last),
    .col_o(w_col),
    .row_o(w_row)
  );

  // pel position: direction picks order, inverting mirrors rows
  always_comb begin
    logic [DIM_W-1:0] r;
    r = w_row;
    if (op_q == draw_ctl_pkg::OP_BLOCK_INV) begin
      r = hgt_q - w_row;
    end
    if (is_line) begin
      px = cur_q.x;
      py = cur_q.y;
    end else begin
      px = dir_q.x_negative_flag ? dest_q.x - 14'(w_col)
                                 : dest_q.x + 14'(w_col);
      py = dir_q.y_negative_flag ? dest_q.y - 14'(r)
                                 : dest_q.y + 14'(r);
    end
  end

  // scissor at the destination bitmap edge
  assign in_bitmap = px >= 0 && py >= 0 &&
    px <= $signed({2'b00, clip_w_q}) && py <= $signed({2'b00, clip_h_q});
  // fill plane pel for this position: outline marks are modelled as
  // column 0 and the column held in the LENGTH_ADDR register
  assign outline_pel = (w_col == len_q) || (w_col == 12'h000);

  // engine state; ends the very cycle the last pel is issued
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (launch) state_q <= ST_RUN;
        ST_RUN: begin
          if (w_last) begin
            state_q <= ST_IDLE;
          end else if (hold) begin
            state_q <= ST_PAUSE;
          end
        end
        ST_PAUSE: begin
          // the walker runs again one cycle before this state leaves pause
          if (w_last) begin
            state_q <= ST_IDLE;
          end else if (!hold) begin
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pel write stream; fill toggles at outline pels per row
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pel_we_q <= 1'b0;
      pel_fill_q <= 1'b0;
      pel_addr_q <= 28'h0000000;
      fill_on_q <= 1'b0;
    end else begin
      pel_we_q <= w_valid && in_bitmap;
      pel_addr_q <= {py, px};
      if (op_q == draw_ctl_pkg::OP_BLOCK_FILL && w_valid) begin
        // toggle before the pel: left edge in, right edge out
        if (w_col == '0) begin
          fill_on_q <= 1'b1;
          pel_fill_q <= w_row != hgt_q; // bottom row out
        end else if (outline_pel) begin
          fill_on_q <= !fill_on_q;
          pel_fill_q <= 1'b0;
        end else begin
          pel_fill_q <= fill_on_q && w_row != hgt_q;
        end
      end else begin
        pel_fill_q <= 1'b0;
      end
    end
  end

  // line stepping leaves parameters updated for continuation
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      err_q <= 16'h0000;
      k1_q <= 16'h0000;
      k2_q <= 16'h0000;
      cur_q <= '0;
      pat_x_q <= 14'h0000;
    end else if (wr_fire && aw_q == draw_ctl_pkg::LINE_ADDR) begin
      err_q <= w_q[15:0];
    end else if (wr_fire && aw_q == draw_ctl_pkg::STEP_ADDR) begin
      k1_q <= w_q[15:0];
      k2_q <= w_q[31:16];
    end else if (wr_fire && aw_q == draw_ctl_pkg::DEST_XY_ADDR) begin
      cur_q <= {w_q[13:0], w_q[29:16]};
    end else if (wr_fire && aw_q == draw_ctl_pkg::PAT_X_ADDR) begin
      pat_x_q <= w_q[13:0];
    end else if (w_valid && is_line) begin
      pat_x_q <= pat_x_q + 14'h0001;
      if (err_q[15]) begin
        err_q <= err_q + k1_q;
        if (dir_q.y_major_flag) begin
          cur_q.y <= dir_q.y_negative_flag ? cur_q.y - 14'sd1
                                           : cur_q.y + 14'sd1;
        end else begin
          cur_q.x <= dir_q.x_negative_flag ? cur_q.x - 14'sd1
                                           : cur_q.x + 14'sd1;
        end
      end else begin
        err_q <= err_q + k2_q;
        cur_q.x <= dir_q.x_negative_flag ? cur_q.x - 14'sd1
                                         : cur_q.x + 14'sd1;
        cur_q.y <= dir_q.y_negative_flag ? cur_q.y - 14'sd1
                                         : cur_q.y + 14'sd1;
      end
    end
  end

  // parameter registers; widths cap each value
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= draw_ctl_pkg::CTRL_RESET;
      op_q <= 4'h0;
      dir_q <= '0;
      len_q <= '0;
      wid_q <= '0;
      hgt_q <= '0;
      clip_w_q <= '0;
      clip_h_q <= '0;
      dest_q <= '0; // defined here, host must still load it
    end else if (wr_fire) begin
      case (aw_q)
        draw_ctl_pkg::ENGINE_CTRL_ADDR: ctrl_q <= w_q[7:0];
        draw_ctl_pkg::LAUNCH_ADDR: op_q <= w_q[27:24];
        draw_ctl_pkg::DIR_ADDR: dir_q <= w_q[2:0];
        draw_ctl_pkg::DEST_XY_ADDR: dest_q <= {w_q[13:0], w_q[29:16]};
        draw_ctl_pkg::LENGTH_ADDR: len_q <= w_q[11:0];
        draw_ctl_pkg::DIM_ADDR: begin
          wid_q <= w_q[11:0];
          hgt_q <= w_q[27:16];
        end
        draw_ctl_pkg::PAT_X_ADDR: begin
          clip_w_q <= w_q[27:16];
          clip_h_q <= w_q[27:16];
        end
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // completion interrupt level, cleared by writing control
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else if (w_last && ctrl_q[draw_ctl_pkg::CTRL_IRQ_EN_BIT]) begin
      irq_q <= 1'b1; // set wins over clear
    end else if (wr_fire && aw_q == draw_ctl_pkg::ENGINE_CTRL_ADDR) begin
      irq_q <= 1'b0;
    end
  end

  // axi write channels, taken in either order, one at a time
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h00000000;
      bvalid_q <= 1'b0;
      bresp_q <= draw_ctl_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= {s_awaddr[7:2], 2'b00};
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_wdata;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= draw_ctl_pkg::RESP_OKAY;
      end else if (bvalid_q && s_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read: control read pauses the walker for one cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ar_have_q <= 1'b0;
      ar_q <= 8'h00;
      ctrl_rd_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ctrl_rd_q <= 1'b0;
      if (s_arvalid && s_arready) begin
        ar_have_q <= 1'b1;
        ar_q <= {s_araddr[7:2], 2'b00};
        ctrl_rd_q <= {s_araddr[7:2], 2'b00} ==
          draw_ctl_pkg::ENGINE_CTRL_ADDR;
      end
      if (ar_have_q && !rvalid_q) begin
        ar_have_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= 32'h00000000;
        case (ar_q)
          draw_ctl_pkg::ENGINE_CTRL_ADDR:
            rdata_q <= {24'h000000, state_q != ST_IDLE, ctrl_q[6:0]};
          draw_ctl_pkg::AUX_STATUS_ADDR:
            rdata_q <= {24'h000000, state_q != ST_IDLE, 7'h00};
          draw_ctl_pkg::LINE_ADDR: rdata_q <= {16'h0000, err_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end else if (rvalid_q && s_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_awready = !aw_have_q && !bvalid_q;
  assign s_wready = !w_have_q && !bvalid_q;
  assign s_bresp = bresp_q;
  assign s_bvalid = bvalid_q;
  assign s_arready = !ar_have_q && !rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = draw_ctl_pkg::RESP_OKAY;
  assign s_rvalid = rvalid_q;
  assign pel_we_o = pel_we_q;
  assign pel_fill_o = pel_fill_q;
  assign pel_addr_o = pel_addr_q;
  assign done_irq_o = irq_q;

  busy_after_launch_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) launch |=> state_q != ST_IDLE)
    else $error("launch did not set busy");
  busy_until_last_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) state_q != ST_IDLE && !w_last
    |=> state_q != ST_IDLE) else $error("busy dropped early");
  done_on_last_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) w_last |=> state_q == ST_IDLE)
    else $error("busy stayed after last pel");
  irq_on_last_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) w_last && ctrl_q[0] |=> irq_q)
    else $error("no completion interrupt");
  ctrl_read_hold_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) hold |=> !pel_we_q)
    else $error("pel issued during control read");
  aux_no_stall_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) s_arvalid && s_arready &&
    s_araddr == draw_ctl_pkg::AUX_STATUS_ADDR |=> !hold)
    else $error("status read stalled engine");
  rd_answer_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) s_arvalid && s_arready |=> ##1 s_rvalid)
    else $error("read answer late");
  clip_write_a: assert property (@(posedge mclk_i)
    disable iff (sys_rst_i) w_valid && !in_bitmap |=> !pel_we_q)
    else $error("pel written outside bitmap");
  launch_c: cover property (@(posedge mclk_i) launch);
  paused_c: cover property (@(posedge mclk_i) state_q == ST_PAUSE);
  fill_c: cover property (@(posedge mclk_i) pel_fill_q);
endmodule // drawing_engine_op_control

// ---- verification/host_axi_model.sv ----
`timescale 1ns/1ps
// host side of the register bus: one write and one read at a time,
// each valid held with its payload until the slave takes it
module host_axi_model (
  // clock
  input wire logic mclk_i,
  // write channels
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // read channels
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // idle bus from time zero
  initial begin
    awaddr_o = 8'h00;
    awvalid_o = 1'b0;
    wdata_o = 32'h0000_0000;
    wvalid_o = 1'b0;
    bready_o = 1'b0;
    araddr_o = 8'h00;
    arvalid_o = 1'b0;
    rready_o = 1'b0;
  end

  // address and data go out together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge mclk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!done) begin
      @(posedge mclk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
      if (bvalid_i) begin
        resp = bresp_i;
        bready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // read: rready stays high until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge mclk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (!done) begin
      @(posedge mclk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
      if (rvalid_i) begin
        d = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule // host_axi_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic pel_we_o, pel_fill_o, done_irq_o, irq_q;
  logic [27:0] pel_addr_o, first_addr;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 31;
  int pels = 0;
  int fills = 0;
  int cyc = 0;
  int t0 = 0;
  int t_done = 0;
  bit want_we = 0;
  bit irq_en = 0;

  always #12.5 mclk_i = ~mclk_i;

  drawing_engine_op_control i_drawing_engine_op_control (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .pel_we_o(pel_we_o),
    .pel_fill_o(pel_fill_o), .pel_addr_o(pel_addr_o),
    .done_irq_o(done_irq_o));

  host_axi_model i_host_axi_model (
    .mclk_i(mclk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
    .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready));

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    i_host_axi_model.wr(a, d, r);
    chk("bresp", {30'h0, r}, {30'h0, draw_ctl_pkg::RESP_OKAY});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    i_host_axi_model.rd(a, d, r);
    chk("rresp", {30'h0, r}, {30'h0, draw_ctl_pkg::RESP_OKAY});
  endtask

  // pels written per op; zero where the count is not predicted
  function automatic int exp_pels(logic [3:0] op, int w, int h, int len);
    if (op[3]) return (w + 1) * (h + 1);
    if (op == draw_ctl_pkg::OP_LINE_WR) return len + 1;
    return 0;
  endfunction

  // filled pels: outlines at column 0 and at len, bottom row left out
  function automatic int exp_fills(logic [3:0] op, int w, int h, int len);
    if (op != draw_ctl_pkg::OP_BLOCK_FILL) return 0;
    if (len == 0 || len > w) return h * (w + 1);
    return h * len;
  endfunction

  // pel monitor; irq rise time is the op's completion stamp
  always @(posedge mclk_i) begin
    cyc++;
    if (pel_we_o === 1'b1) begin
      if (pels == 0) first_addr = pel_addr_o;
      pels++;
      if (pel_fill_o === 1'b1) fills++;
    end
    if (done_irq_o === 1'b1 && irq_q !== 1'b1) begin
      t_done = cyc;
      if (want_we) chk("last_pel_with_irq", {31'h0, pel_we_o}, 32'h1);
    end
    irq_q = done_irq_o;
  end

  // program, launch, optionally peek the main busy bit, wait idle
  task automatic run_op(input logic [3:0] op, input logic [2:0] dir,
                        input int w, input int h, input logic [31:0] len_w,
                        input bit peek);
    int n, ep;
    logic [31:0] d;
    logic [13:0] x, y, fy;
    // kept clear of zero so negative steps stay inside the bitmap
    x = 14'(($random(seed) & 63) + 16);
    y = 14'(($random(seed) & 63) + 16);
    fy = y;
    if (op == draw_ctl_pkg::OP_BLOCK_INV) begin
      fy = dir[1] ? y - 14'(h) : y + 14'(h); // far row comes first
    end
    ep = exp_pels(op, w, h, int'(len_w[11:0]));
    wr(draw_ctl_pkg::DIR_ADDR, {29'h0, dir});
    wr(draw_ctl_pkg::DIM_ADDR, {4'h0, 12'(h), 4'h0, 12'(w)});
    wr(draw_ctl_pkg::LENGTH_ADDR, len_w);
    wr(draw_ctl_pkg::DEST_XY_ADDR, {2'b00, y, 2'b00, x});
    pels = 0;
    fills = 0;
    want_we = (ep > 0);
    wr(draw_ctl_pkg::LAUNCH_ADDR, {4'h0, op, 24'h0});
    t0 = cyc;
    if (ep >= 9) begin
      rd(draw_ctl_pkg::AUX_STATUS_ADDR, d);
      chk("aux_busy_running", {31'h0, d[7]}, 32'h1);
    end
    if (peek) begin
      rd(draw_ctl_pkg::ENGINE_CTRL_ADDR, d); // one main-bit read only
      chk("ctrl_busy_running", {31'h0, d[7]}, 32'h1);
    end
    // no other register is touched until the engine goes idle
    n = 0;
    d = 32'hFFFF_FFFF;
    while (d[7] !== 1'b0 && n < 3000) begin
      rd(draw_ctl_pkg::AUX_STATUS_ADDR, d);
      n++;
    end
    chk("op_finishes", {31'h0, d[7]}, 32'h0);
    if (ep > 0) chk("pel_count", pels, ep);
    if (op[3]) chk("first_pel", first_addr, {fy, x});
    chk("fill_count", fills,
        exp_fills(op, w, h, int'(len_w[11:0])));
    chk("irq_level", {31'h0, done_irq_o}, {31'h0, irq_en});
    wr(draw_ctl_pkg::ENGINE_CTRL_ADDR, {31'h0, irq_en});
    @(posedge mclk_i);
    chk("irq_cleared", {31'h0, done_irq_o}, 32'h0);
  endtask

  draw_ctl_pkg::op_type_t ops[7] = '{draw_ctl_pkg::OP_STEP_RD,
    draw_ctl_pkg::OP_LINE_RD, draw_ctl_pkg::OP_STEP_WR,
    draw_ctl_pkg::OP_LINE_WR, draw_ctl_pkg::OP_BLOCK,
    draw_ctl_pkg::OP_BLOCK_INV, draw_ctl_pkg::OP_BLOCK_FILL};

  // main sequence
  initial begin
    int d1;
    logic [31:0] d;
    repeat (12) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    rd(draw_ctl_pkg::ENGINE_CTRL_ADDR, d);
    chk("ctrl_reset", d, {24'h0, draw_ctl_pkg::CTRL_RESET});
    chk("irq_reset", {31'h0, done_irq_o}, 32'h0);
    rd(8'hF0, d);
    chk("unmapped_read", d, 32'h0);
    irq_en = 1;
    wr(draw_ctl_pkg::ENGINE_CTRL_ADDR, 32'h1);
    // aligned 4096-pel square target of one depth
    wr(draw_ctl_pkg::PAT_X_ADDR, {4'h0, 12'hFFF, 16'h0000});
    // every operation kind with random geometry and direction
    for (int i = 0; i < 7; i++) begin
      run_op(ops[i], 3'($random(seed)), ($random(seed) & 3) + 2,
             ($random(seed) & 3) + 2, ($random(seed) & 7) + 8, 0);
    end
    run_op(draw_ctl_pkg::OP_BLOCK, 3'b000, 3, 2, 32'h0, 0);
    // a main busy read stalls the walker one cycle; aux reads do not
    run_op(draw_ctl_pkg::OP_BLOCK, 3'b000, 7, 7, 32'h0, 0);
    d1 = t_done - t0;
    run_op(draw_ctl_pkg::OP_BLOCK, 3'b000, 7, 7, 32'h0, 1);
    chk("ctrl_read_pause", t_done - t0 - d1, 32'h1);
    // length field keeps 12 bits only; zero length is one pel
    run_op(draw_ctl_pkg::OP_LINE_WR, 3'b001, 2, 2, 32'h0000_1003, 0);
    run_op(draw_ctl_pkg::OP_LINE_WR, 3'b110, 2, 2, 32'h0000_0000, 0);
    // a one-pel target window scissors every pel of a step op
    wr(draw_ctl_pkg::PAT_X_ADDR, 32'h0);
    run_op(draw_ctl_pkg::OP_STEP_WR, 3'b000, 2, 2, 32'h5, 0);
    chk("clipped_pels", pels, 0);
    wr(draw_ctl_pkg::PAT_X_ADDR, {4'h0, 12'hFFF, 16'h0000});
    // interrupt masked: completion stays silent; right outline at col 2
    irq_en = 0;
    wr(draw_ctl_pkg::ENGINE_CTRL_ADDR, 32'h0);
    run_op(draw_ctl_pkg::OP_BLOCK_FILL, 3'b000, 4, 3, 32'h2, 0);
    tally_and_finish();
  end

  // hang guard, far beyond the expected run length
  initial begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    tally_and_finish();
  end
endmodule // tb_top
